// ### core/ppfm_pkg.sv
// Constants, types and register map of the port pin function multiplexer.
// Assumes one 100 MHz clock, synchronous peripheral signals and a simple register port.
// Summary of operation
// - Port D pins are plain general-purpose I/O with no peripheral function.
// - Active oscillator takes upper port E pin as amplifier output, pulldown off.
// - Active oscillator takes lower port E pin as amplifier input, pulldown off.
// - 20-pin: upper port E carries transmit, timer 3, PWM 1, trigger 1.
// - 20-pin: lower port E carries receive, timer 2, PWM 0, trigger 0.
// - Routed transmit line: direction and drive follow the serial interface.
// - Routed receive line forces its pin to input.
// - Timer channel with output compare enabled forces its pin to output.
// - Enabled PWM channel forces its pin to output.
// - Converter trigger only observes the pin; direction and drive unchanged.
// - 20-pin upper port E priority: oscillator, transmit, timer 3, PWM 1, port.
// - 20-pin lower port E priority: oscillator, receive, timer 2, PWM 0, port.
// - Other variants: port E pins owned by oscillator, then port logic.
// - 64/100-pin: port T pins 7,6 carry timer 7,6 over port logic.
// - 48/64/100-pin: port T pin 5 carries timer channel 5 over port logic.
// - Comparator link feeds capture 5 from comparator, pin stays usable.
package ppfm_pkg;

  // ****************************************************************
  // Pin numbering inside the block
  // ****************************************************************
  localparam int PPFM_NUM_PINS = 13;
  localparam int PPFM_NUM_PLAIN = 8;
  localparam int PPFM_PIN_E0 = 8;
  localparam int PPFM_PIN_E1 = 9;
  localparam int PPFM_PIN_T5 = 10;
  localparam int PPFM_PIN_T6 = 11;
  localparam int PPFM_PIN_T7 = 12;

  // ****************************************************************
  // Register port
  // ****************************************************************
  localparam int PPFM_ADDR_W = 4;
  localparam int PPFM_DATA_W = 16;
  localparam logic [3:0] PPFM_REG_CFG = 4'h0;
  localparam logic [3:0] PPFM_REG_OWN_E = 4'h1;
  localparam logic [3:0] PPFM_REG_OWN_T = 4'h2;
  localparam logic [3:0] PPFM_REG_LEVELS = 4'h3;
  localparam logic [3:0] PPFM_REG_ROUTE = 4'h4;

  // Field positions.
  localparam int PPFM_CFG_VARIANT_LSB = 0;
  localparam int PPFM_OWN_LO_LSB = 0;
  localparam int PPFM_OWN_MID_LSB = 3;
  localparam int PPFM_OWN_HI_LSB = 6;
  localparam int PPFM_ROUTE_LINK_BIT = 0;
  localparam int PPFM_ROUTE_SERIAL_BIT = 1;
  localparam int PPFM_ROUTE_TRIG_BIT = 2;
  localparam int PPFM_ROUTE_UPPER_BIT = 3;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [1:0] {
    PPFM_PKG_20,
    PPFM_PKG_48,
    PPFM_PKG_64,
    PPFM_PKG_100
  } ppfm_variant_e;

  // Slot order is the priority order, slot 0 highest.
  typedef enum logic [2:0] {
    PPFM_OWN_OSC,
    PPFM_OWN_SERIAL,
    PPFM_OWN_TIMER,
    PPFM_OWN_PWM,
    PPFM_OWN_PORT
  } ppfm_owner_e;

  localparam int PPFM_SLOTS = 5;
  localparam int PPFM_OWN_W = 3;

  typedef struct packed {
    logic out;
    logic oe;
  } ppfm_drive_s;

  typedef struct packed {
    logic req;
    ppfm_drive_s drv;
  } ppfm_claim_s;

  // Reset values.
  localparam ppfm_variant_e PPFM_VARIANT_RST = PPFM_PKG_64;
  localparam logic [15:0] PPFM_RDATA_RST = 16'h0000;

endpackage

// ### core/ppfm_pin_arbiter.sv
// Fixed-priority owner selection for one pin.
// Assumes slot 0 is the highest priority and the last slot always requests.
module ppfm_pin_arbiter
  import ppfm_pkg::*;
#(
  parameter int SLOTS = PPFM_SLOTS
)
(
  // Claims of all possible owners.
  input wire ppfm_claim_s [SLOTS-1:0] claims_i,
  // Winning owner and its drive.
  output logic [PPFM_OWN_W-1:0] owner_o,
  output ppfm_drive_s drive_o
);

  // Walk from the lowest priority up so the highest requester is left standing.
  always_comb
  begin
    owner_o = PPFM_OWN_W'(SLOTS - 1);
    drive_o = claims_i[SLOTS-1].drv;
    for (int i = SLOTS - 1; i >= 0; i--)
    begin
      if (claims_i[i].req)
      begin
        owner_o = PPFM_OWN_W'(i);
        drive_o = claims_i[i].drv;
      end
    end
  end

endmodule

// ### core/ppfm_pin_mux.sv
// Top of the port pin function multiplexer: owner selection, input routing, registers.
// Assumes peripheral and port signals are synchronous to clk_i; pins are resolved
// from pin_out_o and pin_oe_o outside this block.
module ppfm_pin_mux
  import ppfm_pkg::*;
(
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_i,
  // Register port.
  input wire logic [PPFM_ADDR_W-1:0] reg_addr_i,
  input wire logic [PPFM_DATA_W-1:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [PPFM_DATA_W-1:0] reg_rdata_o,
  // Crystal oscillator.
  input wire logic crystal_amp_active_i,
  input wire logic crystal_amp_output_i,
  output logic crystal_amp_input_o,
  // Serial interface zero.
  input wire logic serial_transmit_en_i,
  input wire logic serial_transmit_line_i,
  input wire logic serial_transmit_oe_i,
  input wire logic serial_receive_en_i,
  output logic serial_receive_line_o,
  // Capture compare unit, one bit per channel.
  input wire logic [7:0] compare_en_i,
  input wire logic [7:0] compare_out_i,
  output logic [7:0] capture_in_o,
  // Pulse width channels zero and one.
  input wire logic [1:0] pulse_width_en_i,
  input wire logic [1:0] pulse_width_out_i,
  // Converter external triggers zero and one.
  input wire logic [1:0] converter_trigger_en_i,
  output logic [1:0] converter_trigger_o,
  // Analog comparator link to capture channel five.
  input wire logic analog_comparator_link_i,
  input wire logic analog_comparator_out_i,
  // General-purpose port logic, indexed by block pin number.
  input wire logic [PPFM_NUM_PINS-1:0] port_dir_i,
  input wire logic [PPFM_NUM_PINS-1:0] port_out_i,
  input wire logic [1:0] port_pulldown_en_i,
  output logic [PPFM_NUM_PINS-1:0] port_in_o,
  // Pins.
  input wire logic [PPFM_NUM_PINS-1:0] pin_in_i,
  output logic [PPFM_NUM_PINS-1:0] pin_out_o,
  output logic [PPFM_NUM_PINS-1:0] pin_oe_o,
  output logic [1:0] pin_pulldown_o
);

  // ****************************************************************
  // Declarations
  // ****************************************************************
  // Configuration and read data.
  ppfm_variant_e variant_q;
  ppfm_variant_e variant_d;
  logic [PPFM_DATA_W-1:0] rdata_q;
  logic [PPFM_DATA_W-1:0] rdata_d;

  // Pin drive and levels.
  logic [PPFM_NUM_PINS-1:0] pin_out_q;
  logic [PPFM_NUM_PINS-1:0] pin_out_d;
  logic [PPFM_NUM_PINS-1:0] pin_oe_q;
  logic [PPFM_NUM_PINS-1:0] pin_oe_d;
  logic [1:0] pulldown_q;
  logic [1:0] pulldown_d;
  logic [PPFM_NUM_PINS-1:0] port_in_q;
  logic [PPFM_NUM_PINS-1:0] port_in_d;

  // Lines to the peripherals.
  logic [7:0] capture_q;
  logic [7:0] capture_d;
  logic [1:0] trigger_q;
  logic [1:0] trigger_d;
  logic receive_q;
  logic receive_d;
  logic crystal_in_q;
  logic crystal_in_d;

  // Owner of each pin.
  logic [PPFM_OWN_W-1:0] owner_q [PPFM_NUM_PINS];
  logic [PPFM_OWN_W-1:0] owner_d [PPFM_NUM_PINS];

  // Per-pin claims and winners.
  ppfm_claim_s [PPFM_SLOTS-1:0] claims [PPFM_NUM_PINS];
  logic [PPFM_OWN_W-1:0] owner_win [PPFM_NUM_PINS];
  ppfm_drive_s drive_win [PPFM_NUM_PINS];

  // Variant decode.
  logic small_pkg;
  logic timer_upper_pkg;
  logic timer_five_pkg;

  // ****************************************************************
  // Package variant decode
  // ****************************************************************

  // The variant is held in a software register so one netlist serves every package.
  assign small_pkg = (variant_q == PPFM_PKG_20);
  assign timer_upper_pkg = (variant_q == PPFM_PKG_64) || (variant_q == PPFM_PKG_100);
  assign timer_five_pkg = !small_pkg;

  // ****************************************************************
  // Claims of every owner on every pin
  // ****************************************************************

  // Each pin gets one claim per priority slot; absent functions never request.
  always_comb
  begin
    for (int p = 0; p < PPFM_NUM_PINS; p++)
    begin
      for (int s = 0; s < PPFM_SLOTS; s++)
      begin
        claims[p][s] = '0;
      end
      // Port logic always requests in the lowest slot.
      claims[p][PPFM_OWN_PORT].req = 1'b1;
      claims[p][PPFM_OWN_PORT].drv.out = port_out_i[p];
      claims[p][PPFM_OWN_PORT].drv.oe = port_dir_i[p];
    end
    // Port D pins (0 to 7) get no peripheral claim at all.

    // Upper port E pin: amplifier output drives the pin.
    claims[PPFM_PIN_E1][PPFM_OWN_OSC].req = crystal_amp_active_i;
    claims[PPFM_PIN_E1][PPFM_OWN_OSC].drv.out = crystal_amp_output_i;
    claims[PPFM_PIN_E1][PPFM_OWN_OSC].drv.oe = 1'b1;

    // Lower port E pin: amplifier input, the pin is only sensed.
    claims[PPFM_PIN_E0][PPFM_OWN_OSC].req = crystal_amp_active_i;
    claims[PPFM_PIN_E0][PPFM_OWN_OSC].drv.out = 1'b0;
    claims[PPFM_PIN_E0][PPFM_OWN_OSC].drv.oe = 1'b0;

    // Peripheral claims on port E other than the oscillator's exist only in the small package.
    // Transmit line keeps the serial interface's own direction and drive.
    claims[PPFM_PIN_E1][PPFM_OWN_SERIAL].req = small_pkg && serial_transmit_en_i;
    claims[PPFM_PIN_E1][PPFM_OWN_SERIAL].drv.out = serial_transmit_line_i;
    claims[PPFM_PIN_E1][PPFM_OWN_SERIAL].drv.oe = serial_transmit_oe_i;
    // Receive line forces the pin to input.
    claims[PPFM_PIN_E0][PPFM_OWN_SERIAL].req = small_pkg && serial_receive_en_i;
    claims[PPFM_PIN_E0][PPFM_OWN_SERIAL].drv.out = 1'b0;
    claims[PPFM_PIN_E0][PPFM_OWN_SERIAL].drv.oe = 1'b0;
    // Output compare forces output on timer channels three and two.
    claims[PPFM_PIN_E1][PPFM_OWN_TIMER].req = small_pkg && compare_en_i[3];
    claims[PPFM_PIN_E1][PPFM_OWN_TIMER].drv.out = compare_out_i[3];
    claims[PPFM_PIN_E1][PPFM_OWN_TIMER].drv.oe = 1'b1;
    claims[PPFM_PIN_E0][PPFM_OWN_TIMER].req = small_pkg && compare_en_i[2];
    claims[PPFM_PIN_E0][PPFM_OWN_TIMER].drv.out = compare_out_i[2];
    claims[PPFM_PIN_E0][PPFM_OWN_TIMER].drv.oe = 1'b1;
    // Enabled PWM channels force output.
    claims[PPFM_PIN_E1][PPFM_OWN_PWM].req = small_pkg && pulse_width_en_i[1];
    claims[PPFM_PIN_E1][PPFM_OWN_PWM].drv.out = pulse_width_out_i[1];
    claims[PPFM_PIN_E1][PPFM_OWN_PWM].drv.oe = 1'b1;
    claims[PPFM_PIN_E0][PPFM_OWN_PWM].req = small_pkg && pulse_width_en_i[0];
    claims[PPFM_PIN_E0][PPFM_OWN_PWM].drv.out = pulse_width_out_i[0];
    claims[PPFM_PIN_E0][PPFM_OWN_PWM].drv.oe = 1'b1;
    // Converter triggers place no claim, so they never touch direction.

    // Port T timer channels.
    claims[PPFM_PIN_T5][PPFM_OWN_TIMER].req = timer_five_pkg && compare_en_i[5];
    claims[PPFM_PIN_T5][PPFM_OWN_TIMER].drv.out = compare_out_i[5];
    claims[PPFM_PIN_T5][PPFM_OWN_TIMER].drv.oe = 1'b1;
    claims[PPFM_PIN_T6][PPFM_OWN_TIMER].req = timer_upper_pkg && compare_en_i[6];
    claims[PPFM_PIN_T6][PPFM_OWN_TIMER].drv.out = compare_out_i[6];
    claims[PPFM_PIN_T6][PPFM_OWN_TIMER].drv.oe = 1'b1;
    claims[PPFM_PIN_T7][PPFM_OWN_TIMER].req = timer_upper_pkg && compare_en_i[7];
    claims[PPFM_PIN_T7][PPFM_OWN_TIMER].drv.out = compare_out_i[7];
    claims[PPFM_PIN_T7][PPFM_OWN_TIMER].drv.oe = 1'b1;
  end

  // ****************************************************************
  // Per-pin priority selection
  // ****************************************************************

  // One arbiter per pin; slot order gives the descending priority.
  for (genvar g = 0; g < PPFM_NUM_PINS; g++)
  begin : g_pin
    ppfm_pin_arbiter #(
      .SLOTS(PPFM_SLOTS)
    ) u_arb (
      .claims_i(claims[g]),
      .owner_o(owner_win[g]),
      .drive_o(drive_win[g])
    );
  end

  // ****************************************************************
  // Pin drive and input routing, next values
  // ****************************************************************

  // Everything is registered once, so pins lag their causes by one clock.
  always_comb
  begin
    for (int p = 0; p < PPFM_NUM_PINS; p++)
    begin
      pin_out_d[p] = drive_win[p].out;
      pin_oe_d[p] = drive_win[p].oe;
      owner_d[p] = owner_win[p];
    end

    // The oscillator switches both pulldowns off whatever else is set.
    pulldown_d = port_pulldown_en_i & {2{~crystal_amp_active_i}};

    // Port logic always sees the pin levels.
    port_in_d = pin_in_i;
    crystal_in_d = pin_in_i[PPFM_PIN_E0];

    // Receive line idles high when it has no pin in this package.
    receive_d = small_pkg ? pin_in_i[PPFM_PIN_E0] : 1'b1;
    // Triggers only sample the pin level.
    trigger_d[0] = small_pkg && converter_trigger_en_i[0] && pin_in_i[PPFM_PIN_E0];
    trigger_d[1] = small_pkg && converter_trigger_en_i[1] && pin_in_i[PPFM_PIN_E1];

    // Absent channels see a steady low.
    capture_d = '0;
    capture_d[2] = small_pkg && pin_in_i[PPFM_PIN_E0];
    capture_d[3] = small_pkg && pin_in_i[PPFM_PIN_E1];
    // The link cuts the pin off capture five; the pin keeps its port or timer use.
    if (analog_comparator_link_i)
    begin
      capture_d[5] = analog_comparator_out_i;
    end
    else
    begin
      capture_d[5] = timer_five_pkg && pin_in_i[PPFM_PIN_T5];
    end
    capture_d[6] = timer_upper_pkg && pin_in_i[PPFM_PIN_T6];
    capture_d[7] = timer_upper_pkg && pin_in_i[PPFM_PIN_T7];
  end

  // ****************************************************************
  // Register port, next values
  // ****************************************************************

  // Read data appear only in the cycle after the read strobe, zero otherwise.
  always_comb
  begin
    variant_d = variant_q;
    rdata_d = PPFM_RDATA_RST;
    // Only configuration takes writes.
    if (reg_wr_i && (reg_addr_i == PPFM_REG_CFG))
    begin
      variant_d = ppfm_variant_e'(reg_wdata_i[PPFM_CFG_VARIANT_LSB +: 2]);
    end

    if (reg_rd_i)
    begin
      case (reg_addr_i)
        PPFM_REG_CFG:
        begin
          rdata_d[PPFM_CFG_VARIANT_LSB +: 2] = variant_q;
        end
        PPFM_REG_OWN_E:
        begin
          rdata_d[PPFM_OWN_LO_LSB +: PPFM_OWN_W] = owner_q[PPFM_PIN_E0];
          rdata_d[PPFM_OWN_MID_LSB +: PPFM_OWN_W] = owner_q[PPFM_PIN_E1];
        end
        PPFM_REG_OWN_T:
        begin
          rdata_d[PPFM_OWN_LO_LSB +: PPFM_OWN_W] = owner_q[PPFM_PIN_T5];
          rdata_d[PPFM_OWN_MID_LSB +: PPFM_OWN_W] = owner_q[PPFM_PIN_T6];
          rdata_d[PPFM_OWN_HI_LSB +: PPFM_OWN_W] = owner_q[PPFM_PIN_T7];
        end
        PPFM_REG_LEVELS:
        begin
          rdata_d[PPFM_NUM_PINS-1:0] = port_in_q;
        end
        PPFM_REG_ROUTE:
        begin
          // Capture must be on for the link to mean anything; software's duty.
          rdata_d[PPFM_ROUTE_LINK_BIT] = analog_comparator_link_i;
          rdata_d[PPFM_ROUTE_SERIAL_BIT] = small_pkg;
          rdata_d[PPFM_ROUTE_TRIG_BIT] = small_pkg;
          rdata_d[PPFM_ROUTE_UPPER_BIT] = timer_upper_pkg;
        end
        default:
        begin
          rdata_d = PPFM_RDATA_RST;
        end
      endcase
    end
  end

  // ****************************************************************
  // State registers
  // ****************************************************************

  // Reset leaves every pin an undriven input owned by the port logic.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      // Receive idles high: no false start bit.
      variant_q <= PPFM_VARIANT_RST;
      rdata_q <= PPFM_RDATA_RST;
      pin_out_q <= '0;
      pin_oe_q <= '0;
      pulldown_q <= '0;
      port_in_q <= '0;
      capture_q <= '0;
      trigger_q <= '0;
      receive_q <= 1'b1;
      crystal_in_q <= 1'b0;
      for (int p = 0; p < PPFM_NUM_PINS; p++)
      begin
        owner_q[p] <= PPFM_OWN_PORT;
      end
    end
    else
    begin
      // All registers load every edge.
      variant_q <= variant_d;
      rdata_q <= rdata_d;
      pin_out_q <= pin_out_d;
      pin_oe_q <= pin_oe_d;
      pulldown_q <= pulldown_d;
      port_in_q <= port_in_d;
      capture_q <= capture_d;
      trigger_q <= trigger_d;
      receive_q <= receive_d;
      crystal_in_q <= crystal_in_d;
      for (int p = 0; p < PPFM_NUM_PINS; p++)
      begin
        owner_q[p] <= owner_d[p];
      end
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  // Straight from the registers.
  assign reg_rdata_o = rdata_q;
  assign pin_out_o = pin_out_q;
  assign pin_oe_o = pin_oe_q;
  assign pin_pulldown_o = pulldown_q;
  assign port_in_o = port_in_q;
  assign capture_in_o = capture_q;
  assign converter_trigger_o = trigger_q;
  assign serial_receive_line_o = receive_q;
  assign crystal_amp_input_o = crystal_in_q;

endmodule

// ### sim/ppfm_pin_mux_properties.sv
// Concurrent checks of the port pin function multiplexer, seen from its top ports.
// Assumes one clock, synchronous active-high reset and a one-cycle pin latency.
module ppfm_pin_mux_properties
  import ppfm_pkg::*;
(
  // Clock, reset and register writes.
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [PPFM_ADDR_W-1:0] reg_addr_i,
  input wire logic [PPFM_DATA_W-1:0] reg_wdata_i,
  input wire logic reg_wr_i,
  // Peripheral requests.
  input wire logic crystal_amp_active_i,
  input wire logic crystal_amp_output_i,
  input wire logic serial_transmit_en_i,
  input wire logic serial_transmit_line_i,
  input wire logic serial_transmit_oe_i,
  input wire logic serial_receive_en_i,
  input wire logic [7:0] compare_en_i,
  input wire logic [7:0] compare_out_i,
  input wire logic [1:0] pulse_width_en_i,
  input wire logic [1:0] pulse_width_out_i,
  input wire logic analog_comparator_link_i,
  input wire logic analog_comparator_out_i,
  input wire logic [PPFM_NUM_PINS-1:0] port_dir_i,
  input wire logic [PPFM_NUM_PINS-1:0] port_out_i,
  // Observed outputs.
  input wire logic [7:0] capture_in_o,
  input wire logic [PPFM_NUM_PINS-1:0] pin_out_o,
  input wire logic [PPFM_NUM_PINS-1:0] pin_oe_o,
  input wire logic [1:0] pin_pulldown_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic live_q, live_d;
  logic [1:0] variant_q, variant_d;

  // Shadow of the package variant; the first edge after reset still shows reset outputs.
  always_comb
  begin
    live_d = !rst_i;
    variant_d = variant_q;
    if (rst_i)
      variant_d = 2'd2;
    else if (reg_wr_i && reg_addr_i == PPFM_REG_CFG)
      variant_d = reg_wdata_i[1:0];
  end

  // Shadow registers.
  always_ff @(posedge clk_i)
  begin
    live_q <= live_d;
    variant_q <= variant_d;
  end

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  // ********************
  // Pin ownership and capture routing
  // ********************
  a_plain_pins_port: assert property (live_q |-> pin_oe_o[7:0] == $past(port_dir_i[7:0]) &&
    (pin_out_o[7:0] & pin_oe_o[7:0]) == ($past(port_out_i[7:0]) & pin_oe_o[7:0]))
    else $error("port D pin not under port control");
  a_osc_upper_drive: assert property (live_q && $past(crystal_amp_active_i) |->
    pin_oe_o[9] && pin_out_o[9] == $past(crystal_amp_output_i) && !pin_pulldown_o[1])
    else $error("upper E pin not carrying oscillator output");
  a_osc_lower_input: assert property (live_q && $past(crystal_amp_active_i) |->
    !pin_oe_o[8] && !pin_pulldown_o[0])
    else $error("lower E pin not released for oscillator");
  a_tx_follows_serial: assert property (live_q && $past(variant_q == 2'd0 && serial_transmit_en_i &&
    !crystal_amp_active_i) |-> pin_oe_o[9] == $past(serial_transmit_oe_i) &&
    (!pin_oe_o[9] || pin_out_o[9] == $past(serial_transmit_line_i)))
    else $error("transmit pin not following serial drive");
  a_rx_forces_input: assert property (live_q && $past(variant_q == 2'd0 && serial_receive_en_i) |->
    !pin_oe_o[8])
    else $error("receive pin driven");
  a_t5_timer_output: assert property (live_q && $past(variant_q != 2'd0 && compare_en_i[5]) |->
    pin_oe_o[10] && pin_out_o[10] == $past(compare_out_i[5]))
    else $error("timer 5 compare not driving its pin");
  a_pwm_last_claim: assert property (live_q && $past(variant_q == 2'd0 && pulse_width_en_i[0] &&
    !crystal_amp_active_i && !serial_receive_en_i && !compare_en_i[2]) |->
    pin_oe_o[8] && pin_out_o[8] == $past(pulse_width_out_i[0]))
    else $error("pwm 0 not driving lower E pin");
  a_other_e_port: assert property (live_q && $past(variant_q != 2'd0 && !crystal_amp_active_i) |->
    pin_oe_o[9:8] == $past(port_dir_i[9:8]))
    else $error("port E pin not under port control");
  a_upper_t_timer: assert property (live_q && $past(variant_q[1] && compare_en_i[7]) |->
    pin_oe_o[12] && pin_out_o[12] == $past(compare_out_i[7]))
    else $error("timer 7 compare not driving its pin");
  a_link_capture: assert property (live_q && $past(analog_comparator_link_i) |->
    capture_in_o[5] == $past(analog_comparator_out_i))
    else $error("capture 5 not fed by comparator");

  // Main scenarios reached.
  c_osc_over_tx: cover property (live_q && $past(crystal_amp_active_i && serial_transmit_en_i && variant_q == 2'd0));
  c_pwm_claim: cover property (live_q && $past(variant_q == 2'd0 && pulse_width_en_i[0] && !compare_en_i[2]));
  c_link_on: cover property (live_q && $past(analog_comparator_link_i && variant_q != 2'd0));
endmodule

// ### sim/ppfm_pad_model.sv
// Pad model standing at the pins: resolves each pin level from the block's drive.
// Assumes pulldowns exist on the two port E pins only.
module ppfm_pad_model
  import ppfm_pkg::*;
(
  // Drive from the multiplexer.
  input wire logic [PPFM_NUM_PINS-1:0] pin_out_i,
  input wire logic [PPFM_NUM_PINS-1:0] pin_oe_i,
  input wire logic [1:0] pin_pulldown_i,
  // Level of a released, unpulled pin; the bench changes it every step.
  input wire logic [PPFM_NUM_PINS-1:0] float_i,
  // Resolved pin levels.
  output logic [PPFM_NUM_PINS-1:0] pin_level_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [PPFM_NUM_PINS-1:0] pull;

  // A released pin never keeps the last driven value, so stale reads show up.
  always_comb
  begin
    pull = '0;
    pull[PPFM_PIN_E1:PPFM_PIN_E0] = pin_pulldown_i;
    pin_level_o = (pin_oe_i & pin_out_i) | (~pin_oe_i & ~pull & float_i);
  end
endmodule

// ### sim/ppfm_pin_mux_tb.sv
// Self-checking bench of the port pin function multiplexer.
// Assumes the pad model closes the loop from pin drive back to pin level.
module ppfm_pin_mux_tb
  import ppfm_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wr = 1'b0, rd = 1'b0, osc = 0, xo = 0, txe = 0, txl = 0, txo = 0, rxe = 0, lnk = 0, cmpv = 0;
  logic cin, rxl;
  logic [3:0] addr = '0;
  logic [15:0] wdat = '0, rdat;
  logic [7:0] ce = '0, co = '0, cap;
  logic [1:0] pe = '0, po = '0, te = '0, pde = '0, trg, pd;
  logic [12:0] dir = '0, pout = '0, flt = '0, pin_in, pin_out, pin_oe, port_in, eo, ed;
  logic [2:0] own [13];
  logic [31:0] seed = 32'h86dc67f1;
  int err_total = 0;
  int samples_checked = 0;

  // 100 MHz clock.
  initial
  begin
    forever #5 clk_i = ~clk_i;
  end

  ppfm_pin_mux dut (.clk_i, .rst_i, .reg_addr_i(addr), .reg_wdata_i(wdat), .reg_wr_i(wr), .reg_rd_i(rd),
    .reg_rdata_o(rdat), .crystal_amp_active_i(osc), .crystal_amp_output_i(xo), .crystal_amp_input_o(cin),
    .serial_transmit_en_i(txe), .serial_transmit_line_i(txl), .serial_transmit_oe_i(txo),
    .serial_receive_en_i(rxe), .serial_receive_line_o(rxl), .compare_en_i(ce), .compare_out_i(co),
    .capture_in_o(cap), .pulse_width_en_i(pe), .pulse_width_out_i(po), .converter_trigger_en_i(te),
    .converter_trigger_o(trg), .analog_comparator_link_i(lnk), .analog_comparator_out_i(cmpv),
    .port_dir_i(dir), .port_out_i(pout), .port_pulldown_en_i(pde), .port_in_o(port_in), .pin_in_i(pin_in),
    .pin_out_o(pin_out), .pin_oe_o(pin_oe), .pin_pulldown_o(pd));

  ppfm_pad_model pads (.pin_out_i(pin_out), .pin_oe_i(pin_oe), .pin_pulldown_i(pd), .float_i(flt),
    .pin_level_o(pin_in));

  // ********************
  // Helpers
  // ********************
  function automatic logic [31:0] next_rand(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      err_total++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk_i);
    addr <= a;
    wdat <= d;
    wr <= 1'b1;
    @(posedge clk_i);
    wr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe.
  task automatic rd_reg(input logic [3:0] a, input logic [15:0] e);
    @(posedge clk_i);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk_i);
    rd <= 1'b0;
    #1;
    chk(rdat, e);
  endtask

  // New random requests from every peripheral and the port logic at once.
  task automatic shake();
    logic [31:0] a, b, c;
    a = next_rand(seed);
    b = next_rand(a);
    c = next_rand(b);
    seed = c;
    @(posedge clk_i);
    osc <= a[1:0] == 2'b00;
    {xo, txe, txl, txo, rxe, lnk, cmpv} <= a[8:2];
    {pe, po, te, pde} <= a[16:9];
    {ce, co} <= b[15:0];
    dir <= b[28:16];
    pout <= a[29:17];
    flt <= c[12:0];
  endtask

  task automatic claim(input int p, input logic [2:0] o, input logic e, input logic d);
    own[p] = o;
    eo[p] = e;
    ed[p] = d;
  endtask

  // Claims are applied lowest priority first, so a later claim wins; serial claims come last, only without the oscillator.
  task automatic judge(input int v);
    logic [7:0] ecap;
    eo = dir;
    ed = pout;
    foreach (own[i]) own[i] = 3'd4;
    for (int k = 0; k < 2; k++)
    begin
      if (v == 0 && pe[k]) claim(8 + k, 3'd3, 1'b1, po[k]);
      if (v == 0 && ce[2 + k]) claim(8 + k, 3'd2, 1'b1, co[2 + k]);
      if (osc) claim(8 + k, 3'd0, k[0], xo);
    end
    if (v == 0 && rxe && !osc) claim(8, 3'd1, 1'b0, 1'b0);
    if (v == 0 && txe && !osc) claim(9, 3'd1, txo, txl);
    if (v != 0 && ce[5]) claim(10, 3'd2, 1'b1, co[5]);
    if (v >= 2 && ce[6]) claim(11, 3'd2, 1'b1, co[6]);
    if (v >= 2 && ce[7]) claim(12, 3'd2, 1'b1, co[7]);
    ecap = '0;
    ecap[3:2] = (v == 0) ? pin_in[9:8] : 2'b00;
    ecap[5] = lnk ? cmpv : (v != 0) & pin_in[10];
    ecap[7:6] = (v >= 2) ? pin_in[12:11] : 2'b00;
    chk(rdat, 16'h0000);
    chk(16'(pin_oe), 16'(eo));
    chk(16'(pin_out & eo), 16'(ed & eo));
    chk(16'(pd), 16'(pde & ~{osc, osc}));
    chk(16'(cap), 16'(ecap));
    chk(16'({trg, rxl, cin}),
      16'({(v == 0) ? te & pin_in[9:8] : 2'b00, (v == 0) ? pin_in[8] : 1'b1, pin_in[8]}));
    chk(16'(port_in), 16'(pin_in));
    rd_reg(PPFM_REG_OWN_E, {10'd0, own[9], own[8]});
    rd_reg(PPFM_REG_OWN_T, {7'd0, own[12], own[11], own[10]});
    rd_reg(PPFM_REG_ROUTE, {12'd0, v >= 2, v == 0, v == 0, lnk});
    rd_reg(PPFM_REG_LEVELS, {3'd0, pin_in});
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // ********************
  // Sequence
  // ********************
  initial
  begin
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    rd_reg(PPFM_REG_CFG, 16'h0002);
    rd_reg(PPFM_REG_OWN_E, 16'h0024);
    rd_reg(4'hf, 16'h0000);
    $display("reset test done");
    for (int v = 0; v < 4; v++)
    begin
      seed = next_rand(seed);
      wr_reg(PPFM_REG_CFG, {seed[15:2], 2'(v)});
      wr_reg(4'h9, seed[31:16]);
      wr_reg(PPFM_REG_OWN_E, 16'hffff);
      rd_reg(PPFM_REG_CFG, 16'(v));
      repeat (60)
      begin
        shake();
        repeat (3) @(posedge clk_i);
        #1;
        judge(v);
      end
      $display("variant %0d test done", v);
    end
    print_verdict();
  end

  // Roughly 2900 cycles are expected; the limit leaves wide margin for a hang.
  initial
  begin
    #300000;
    err_total++;
    print_verdict();
  end
endmodule

bind ppfm_pin_mux ppfm_pin_mux_properties u_props (.clk_i, .rst_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i,
  .crystal_amp_active_i, .crystal_amp_output_i, .serial_transmit_en_i, .serial_transmit_line_i,
  .serial_transmit_oe_i, .serial_receive_en_i, .compare_en_i, .compare_out_i, .pulse_width_en_i,
  .pulse_width_out_i, .analog_comparator_link_i, .analog_comparator_out_i, .port_dir_i, .port_out_i,
  .capture_in_o, .pin_out_o, .pin_oe_o, .pin_pulldown_o);
